// file: include/adc_serial_regs.vh
// constants for the converter serial result interface
`ifndef ADC_SERIAL_REGS_VH
`define ADC_SERIAL_REGS_VH
// -----------------------------------------------------------------
// frame and timing
// -----------------------------------------------------------------
`define RESULT_BITS 24
`define BIT_CNT_W 5
`define LAST_BIT 5'h17
`define SCK_DIV 8
`define CLK_PERIOD_NS 5
`define STATUS_TEST_DELAY_NS 23000
`define CONV_CYCLES_DEFAULT 32'h01fb_d0a0
`define FIFO_DEPTH 16
`define PU_HOLD 2'h3
`endif

// file: src/result_fifo.v
// first-word-fall-through result fifo with valid/ready on both sides
`timescale 1ns/1ps
module result_fifo #(
    parameter WIDTH = 24,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clk,
    input wire srst,
    input wire [WIDTH-1:0] in_data,
    input wire in_valid,
    output wire in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire out_valid,
    input wire out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wr_q;
    reg [AW:0] rd_q;
    wire full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    wire empty = (wr_q == rd_q);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rd_q[AW-1:0]];
    always @(posedge clk) begin
        if (srst) begin
            wr_q <= {(AW+1){1'b0}};
            rd_q <= {(AW+1){1'b0}};
        end else begin
            if (in_valid && !full) begin
                mem[wr_q[AW-1:0]] <= in_data;
                wr_q <= wr_q + 1'b1;
            end
            if (out_ready && !empty)
                rd_q <= rd_q + 1'b1;
        end
    end
endmodule

// file: src/adc_serial_if.v
// serial result and status interface of the converter
`timescale 1ns/1ps
`include "adc_serial_regs.vh"
// Summary of operation
// - cs fall samples sck; low selects external
// - sdo released whenever cs is high
// - cs low in convert/sleep shows busy
// - conversion end enters sleep regardless of cs
// - sleep holds result until sck rise
// - sdo changes on sck falling edges
// - external single cycle: 24th fall restarts
// - cs rise during readout restarts conversion
// - cs tied low: mode fixed at reset end
// - two-wire: result loads when busy falls
// - two-wire: 24th fall drives sdo, restarts
// - pull-up on sck during cs fall
// - internal mode: cs fall drives sck low
// - internal mode: sck rises after test delay
// - cs rise before delay keeps sleep
// - internal: 24 rises, then sck high, restart
// - internal: cs rise during readout restarts
// - pull-up off while sck low
// - cs rise in status test re-enables pull-up
// - internal sck is conversion clock over eight times OSC_DIV
module adc_serial_if #(
    parameter CONV_CYCLES = `CONV_CYCLES_DEFAULT,
    parameter OSC_DIV = 1
) (
    // clock and reset
    input wire CLK_SYS,
    input wire SRST,
    // serial pins
    input wire CS_N,
    input wire SCK_IN,
    output reg SCK_OUT,
    output reg SCK_OE,
    output reg SCK_PULLUP_EN,
    output reg SDO_OUT,
    output reg SDO_OE,
    // result source from the modulator
    input wire [`RESULT_BITS-1:0] SAMPLE_DATA,
    input wire SAMPLE_VALID,
    output reg SAMPLE_READY,
    // status
    output reg BUSY,
    output reg EXT_MODE
);
    // -----------------------------------------------------------------
    // timing counts
    // -----------------------------------------------------------------
    // status test delay is fixed for the internal oscillator; an external
    // oscillator would shorten it, which this block does not model
    localparam integer DELAY_CYCLES = (`STATUS_TEST_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    localparam integer HALF_SCK = (`SCK_DIV * OSC_DIV) / 2;
    localparam [1:0] S_CONV = 2'h0;
    localparam [1:0] S_SLEEP = 2'h1;
    localparam [1:0] S_OUT = 2'h2;

    function [31:0] inc32;
        input [31:0] v;
        begin
            inc32 = v + 32'h0000_0001;
        end
    endfunction

    // true on the last cycle of a count that runs from zero to limit-1
    function reached;
        input [31:0] cnt;
        input [31:0] limit;
        begin
            reached = (cnt >= limit - 32'h0000_0001);
        end
    endfunction

    // -----------------------------------------------------------------
    // pin synchronisers
    // -----------------------------------------------------------------
    reg cs_m_q, cs_s_q, cs_p_q;
    reg sck_m_q, sck_s_q, sck_p_q;
    always @(posedge CLK_SYS) begin
        cs_m_q <= CS_N;
        cs_s_q <= cs_m_q;
        cs_p_q <= cs_s_q;
        sck_m_q <= SCK_IN;
        sck_s_q <= sck_m_q;
        sck_p_q <= sck_s_q;
    end
    wire cs_fall = cs_p_q && !cs_s_q;
    wire cs_rise = !cs_p_q && cs_s_q;
    wire sck_rise = !sck_p_q && sck_s_q;
    wire sck_fall = sck_p_q && !sck_s_q;

    // -----------------------------------------------------------------
    // result buffer
    // -----------------------------------------------------------------
    wire [`RESULT_BITS-1:0] fifo_data;
    wire fifo_valid;
    wire fifo_in_ready;
    reg fifo_pop;
    result_fifo #(.WIDTH(`RESULT_BITS), .DEPTH(`FIFO_DEPTH), .AW(4)) u_fifo (
        .clk(CLK_SYS),
        .srst(SRST),
        .in_data(SAMPLE_DATA),
        .in_valid(SAMPLE_VALID),
        .in_ready(fifo_in_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop)
    );

    // -----------------------------------------------------------------
    // main state
    // -----------------------------------------------------------------
    reg [1:0] state_q;
    reg [31:0] conv_cnt_q;
    reg [31:0] dly_cnt_q;
    reg [31:0] div_cnt_q;
    reg [`RESULT_BITS-1:0] shift_q;
    reg [`BIT_CNT_W-1:0] bit_q;
    reg mode_init_q;
    reg rose_q;
    reg timing_q;
    reg [1:0] pu_hold_q;
    wire conv_done = reached(conv_cnt_q, CONV_CYCLES);
    wire dly_done = reached(dly_cnt_q, DELAY_CYCLES);
    wire half_done = reached(div_cnt_q, HALF_SCK);

    always @(posedge CLK_SYS) begin
        fifo_pop <= 1'b0;
        if (SRST) begin
            state_q <= S_CONV;
            conv_cnt_q <= 32'h0;
            dly_cnt_q <= 32'h0;
            div_cnt_q <= 32'h0;
            shift_q <= {`RESULT_BITS{1'b0}};
            bit_q <= {`BIT_CNT_W{1'b0}};
            mode_init_q <= 1'b1;
            rose_q <= 1'b0;
            timing_q <= 1'b0;
            BUSY <= 1'b1;
            EXT_MODE <= 1'b0;
            SCK_OUT <= 1'b1;
            SCK_OE <= 1'b0;
            SDO_OUT <= 1'b1;
        end else begin
            // mode strap caught once synchronisers settle after reset
            if (mode_init_q && !cs_p_q && !cs_s_q) begin
                mode_init_q <= 1'b0;
                EXT_MODE <= !sck_s_q;
            end else if (cs_p_q || cs_s_q)
                mode_init_q <= 1'b0;
            if (cs_fall) begin
                EXT_MODE <= !sck_s_q;
            end
            case (state_q)
            S_CONV: begin
                BUSY <= 1'b1;
                if (conv_done) begin
                    // conversion ends on its own, cs level ignored
                    conv_cnt_q <= 32'h0;
                    state_q <= S_SLEEP;
                    BUSY <= 1'b0;
                    if (fifo_valid) begin
                        shift_q <= fifo_data;
                        fifo_pop <= 1'b1;
                    end
                    timing_q <= !cs_s_q;
                    dly_cnt_q <= 32'h0;
                end else
                    conv_cnt_q <= inc32(conv_cnt_q);
            end
            S_SLEEP: begin
                BUSY <= 1'b0;
                if (cs_fall)
                    timing_q <= 1'b1;
                if (EXT_MODE) begin
                    if (!cs_s_q && sck_rise) begin
                        state_q <= S_OUT;
                        bit_q <= {`BIT_CNT_W{1'b0}};
                    end
                end else if (cs_s_q) begin
                    timing_q <= 1'b0;
                    dly_cnt_q <= 32'h0;
                end else if (timing_q) begin
                    if (dly_done) begin
                        state_q <= S_OUT;
                        SCK_OUT <= 1'b1;
                        rose_q <= 1'b1;
                        bit_q <= {`BIT_CNT_W{1'b0}};
                        div_cnt_q <= 32'h0;
                        timing_q <= 1'b0;
                    end else
                        dly_cnt_q <= inc32(dly_cnt_q);
                end
            end
            S_OUT: begin
                if (cs_rise) begin
                    state_q <= S_CONV;
                    SCK_OUT <= 1'b1;
                end else if (EXT_MODE) begin
                    if (sck_fall) begin
                        if (bit_q == `LAST_BIT)
                            state_q <= S_CONV;
                        else begin
                            SDO_OUT <= shift_q[`RESULT_BITS-1];
                            shift_q <= {shift_q[`RESULT_BITS-2:0], 1'b0};
                            bit_q <= bit_q + 1'b1;
                        end
                    end
                end else if (half_done) begin
                    div_cnt_q <= 32'h0;
                    if (rose_q) begin
                        if (bit_q == `LAST_BIT)
                            state_q <= S_CONV;
                        else begin
                            SCK_OUT <= 1'b0;
                            rose_q <= 1'b0;
                            SDO_OUT <= shift_q[`RESULT_BITS-1];
                            shift_q <= {shift_q[`RESULT_BITS-2:0], 1'b0};
                        end
                    end else begin
                        SCK_OUT <= 1'b1;
                        rose_q <= 1'b1;
                        bit_q <= bit_q + 1'b1;
                    end
                end else
                    div_cnt_q <= inc32(div_cnt_q);
            end
            default: state_q <= S_CONV;
            endcase
            // busy / sdo presentation outside readout
            if (state_q != S_OUT || (state_q == S_OUT && (cs_rise ||
                (EXT_MODE && sck_fall && bit_q == `LAST_BIT) ||
                (!EXT_MODE && rose_q && bit_q == `LAST_BIT && half_done)))) begin
                if (state_q == S_OUT)
                    SDO_OUT <= 1'b1;
                else if (state_q == S_CONV)
                    SDO_OUT <= !conv_done;
                else if (!(state_q == S_SLEEP && !EXT_MODE && timing_q && !cs_s_q && dly_done))
                    SDO_OUT <= 1'b0;
            end
            // sck drive in internal mode: low on select, off when deselected;
            // held off in the select-edge and strap cycles, where the mode
            // is still being decided, so sck is never driven in external mode
            if (!EXT_MODE && !cs_s_q && !cs_fall && !mode_init_q) begin
                SCK_OE <= 1'b1;
                // first driven cycle is low; after a readout sck stays high until sleep, which drives it low
                if (!SCK_OE || (state_q == S_SLEEP && !(timing_q && dly_done)))
                    SCK_OUT <= 1'b0;
            end else begin
                SCK_OE <= 1'b0;
                if (state_q != S_OUT)
                    SCK_OUT <= 1'b1;
            end
        end
    end

    // -----------------------------------------------------------------
    // pin enable and buffer flow
    // -----------------------------------------------------------------
    always @(posedge CLK_SYS) begin
        if (SRST) begin
            SDO_OE <= 1'b0;
            SAMPLE_READY <= 1'b0;
        end else begin
            SDO_OE <= !cs_s_q;
            SAMPLE_READY <= fifo_in_ready;
        end
    end

    // -----------------------------------------------------------------
    // sck pull-up
    // -----------------------------------------------------------------
    // the synchronised pin trails the pin by two clocks, so right after a
    // select edge the old low level is ignored until the chain catches up;
    // otherwise the pull-up would switch itself off before it could act
    always @(posedge CLK_SYS) begin
        if (SRST) begin
            SCK_PULLUP_EN <= 1'b1;
            pu_hold_q <= 2'h0;
        end else if (cs_fall || cs_rise) begin
            SCK_PULLUP_EN <= 1'b1;
            pu_hold_q <= `PU_HOLD;
        end else begin
            if (pu_hold_q != 2'h0)
                pu_hold_q <= pu_hold_q - 2'h1;
            // own low drive turns it off at once
            if (SCK_OE && !SCK_OUT)
                SCK_PULLUP_EN <= 1'b0;
            else if (pu_hold_q == 2'h0 && !sck_s_q)
                SCK_PULLUP_EN <= 1'b0;
        end
    end
endmodule

// file: tb/adc_serial_if_sva.sv
// port assertions for the converter serial interface
`timescale 1ns/1ps
module adc_serial_if_sva (
    // clock and reset
    input wire CLK_SYS,
    input wire SRST,
    // serial pins
    input wire CS_N,
    input wire SCK_IN,
    input wire SCK_OUT,
    input wire SCK_OE,
    input wire SCK_PULLUP_EN,
    input wire SDO_OUT,
    input wire SDO_OE,
    // status
    input wire BUSY,
    input wire EXT_MODE
);
    // ----
    // properties
    // ----
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SRST);
    AST_SDO_RELEASE: assert property (CS_N [*4] |-> !SDO_OE)
        else $error("sdo driven while deselected");
    AST_SDO_DRIVE: assert property (!CS_N [*6] |-> SDO_OE)
        else $error("sdo not driven while selected");
    AST_BUSY_FLAG: assert property ((BUSY && SDO_OE) [*2] |-> SDO_OUT)
        else $error("busy flag not shown on sdo");
    AST_SLEEP_FLAG: assert property ($fell(BUSY) && SDO_OE |-> ##[0:1] !SDO_OUT)
        else $error("sleep flag not shown on sdo");
    AST_RESTART_SDO: assert property ($rose(BUSY) && SDO_OE |-> ##[0:1] SDO_OUT)
        else $error("sdo low at conversion restart");
    AST_SCK_FIRST_LOW: assert property ($rose(SCK_OE) |-> !SCK_OUT)
        else $error("sck not driven low on select");
    AST_SCK_OWNER: assert property (SCK_OE |-> !EXT_MODE)
        else $error("sck driven in external mode");
    AST_PULLUP_OFF: assert property ((!SCK_IN && $stable(CS_N)) [*8] |-> !SCK_PULLUP_EN)
        else $error("pull-up on while sck low");
    AST_INT_HALF: assert property ($fell(SCK_OUT) && $past(SCK_OE) && SCK_OE
        |-> !SCK_OUT [*4] ##1 SCK_OUT)
        else $error("internal sck half period wrong");
endmodule
bind adc_serial_if adc_serial_if_sva chk (.CLK_SYS(CLK_SYS), .SRST(SRST), .CS_N(CS_N), .SCK_IN(SCK_IN),
    .SCK_OUT(SCK_OUT), .SCK_OE(SCK_OE), .SCK_PULLUP_EN(SCK_PULLUP_EN), .SDO_OUT(SDO_OUT),
    .SDO_OE(SDO_OE), .BUSY(BUSY), .EXT_MODE(EXT_MODE));

// file: tb/serial_master.sv
// serial master model with sck and sdo pin resolution
`timescale 1ns/1ps
module serial_master (
    // clock
    input wire clk,
    // device side of the pins
    input wire sck_out,
    input wire sck_oe,
    input wire sck_pullup_en,
    input wire sdo_out,
    input wire sdo_oe,
    // pins
    output reg cs_n,
    output wire sck_pin
);
    reg drv_en = 1'b1;
    reg drv_val = 1'b0;
    reg keep_q = 1'b0;
    reg last_q = 1'b0;
    reg [23:0] cap_q = 24'h000000;
    integer ncap = 0;
    wire sdo_pin;
    // undriven sck is pulled high while the pull-up is on, else keeps its level; released sdo toggles so it never looks valid
    assign sck_pin = sck_oe ? sck_out : drv_en ? drv_val : (sck_pullup_en | keep_q);
    assign sdo_pin = sdo_oe ? sdo_out : ~last_q;
    initial cs_n = 1'b1;
    always @(posedge clk) begin
        keep_q <= sck_pin;
        last_q <= sdo_pin;
        if (!cs_n && sck_pin && !keep_q) begin
            cap_q <= {cap_q[22:0], sdo_pin};
            ncap <= ncap + 1;
        end
    end
    task sel(input val, input rel);
        begin
            @(posedge clk);
            drv_en <= 1'b1;
            drv_val <= val;
            ncap <= 0;
            repeat (6) @(posedge clk);
            drv_en <= !rel;
            repeat (2) @(posedge clk);
            cs_n <= 1'b0;
        end
    endtask
    task desel;
        begin
            @(posedge clk);
            cs_n <= 1'b1;
        end
    endtask
    task pulses(input integer n);
        integer i;
        begin
            for (i = 0; i < n; i = i + 1) begin
                repeat (6) @(posedge clk);
                drv_val <= 1'b1;
                repeat (6) @(posedge clk);
                drv_val <= 1'b0;
            end
        end
    endtask
endmodule

// file: tb/adc_serial_if_tb.sv
// self-checking bench for the converter serial interface
`timescale 1ns/1ps
`include "adc_serial_regs.vh"
`define CHECK(nm, e, g) begin n_compared = n_compared + 1; if ((g) !== (e)) begin fails = fails + 1; \
    $display("unexpected %s: expected %h, seen %h", nm, e, g); end end
module adc_serial_if_tb;
    reg clk_sys = 1'b0;
    reg srst = 1'b1;
    reg [23:0] sample_data = 24'ha5c35a;
    reg sample_valid = 1'b0;
    wire cs_n, sck_pin, sck_out, sck_oe, pullup_en, sdo_out, sdo_oe, sample_ready, busy, ext_mode;
    integer fails = 0;
    integer n_compared = 0;
    integer k;
    adc_serial_if #(.CONV_CYCLES(200), .OSC_DIV(1)) dut (.CLK_SYS(clk_sys), .SRST(srst), .CS_N(cs_n),
        .SCK_IN(sck_pin), .SCK_OUT(sck_out), .SCK_OE(sck_oe), .SCK_PULLUP_EN(pullup_en), .SDO_OUT(sdo_out),
        .SDO_OE(sdo_oe), .SAMPLE_DATA(sample_data), .SAMPLE_VALID(sample_valid), .SAMPLE_READY(sample_ready),
        .BUSY(busy), .EXT_MODE(ext_mode));
    serial_master m (.clk(clk_sys), .sck_out(sck_out), .sck_oe(sck_oe), .sck_pullup_en(pullup_en),
        .sdo_out(sdo_out), .sdo_oe(sdo_oe), .cs_n(cs_n), .sck_pin(sck_pin));
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    task tick(input integer n);
        begin
            repeat (n) @(posedge clk_sys);
            #1;
        end
    endtask
    task end_of_test;
        begin
            $display("compared %0d, mismatches %0d", n_compared, fails);
            if (fails == 0 && n_compared > 0) $display("Result: passed");
            else $display("Result: failed");
            $finish;
        end
    endtask
    // waits are bounded so a stuck design ends the run
    task wait_on(input bits, input integer n);
        begin
            k = 0;
            while ((bits ? m.ncap < n : busy !== n[0]) && k < 6000) begin
                tick(1);
                k = k + 1;
            end
            if (k >= 6000) begin
                fails = fails + 1;
                $display("unexpected wait timeout");
                end_of_test;
            end
        end
    endtask
    // ----
    // scenarios
    // ----
    task t_fill;
        begin
            `CHECK("reset", 4'h8, {busy, sdo_oe, ext_mode, sck_oe})
            @(posedge clk_sys) sample_valid <= 1'b1;
            tick(20);
            `CHECK("sample_ready", 1'b0, sample_ready)
            @(posedge clk_sys) sample_valid <= 1'b0;
        end
    endtask
    task t_ext_read;
        begin
            m.sel(1'b0, 1'b0);
            tick(6);
            `CHECK("ext busy", 2'b11, {ext_mode, sdo_out})
            wait_on(1'b0, 0);
            tick(3);
            `CHECK("sleep flag", 1'b0, sdo_out)
            m.pulses(24);
            tick(8);
            `CHECK("ext frame", {1'b0, sample_data[23:1]}, m.cap_q)
            `CHECK("ext restart", 2'b11, {busy, sdo_out})
            m.desel;
            tick(6);
            `CHECK("sdo_oe", 1'b0, sdo_oe)
        end
    endtask
    task t_abort;
        begin
            wait_on(1'b0, 0);
            m.sel(1'b0, 1'b0);
            m.pulses(5);
            m.desel;
            tick(8);
            `CHECK("abort", 1'b1, busy)
        end
    endtask
    task t_int_read;
        begin
            m.sel(1'b1, 1'b1);
            tick(6);
            `CHECK("int select", 3'b100, {sck_oe, sck_out, ext_mode})
            wait_on(1'b0, 0);
            wait_on(1'b1, 1);
            `CHECK("test delay", 1'b1, k >= 4599 && k <= 4606)
            wait_on(1'b1, 24);
            tick(8);
            `CHECK("int frame", {1'b0, sample_data[23:1]}, m.cap_q)
            `CHECK("int end", 3'b111, {sck_out, busy, sdo_out})
            m.desel;
        end
    endtask
    task t_peek;
        begin
            wait_on(1'b0, 0);
            m.sel(1'b1, 1'b1);
            tick(200);
            `CHECK("pull-up off", 1'b0, pullup_en)
            m.desel;
            tick(8);
            `CHECK("peek", 3'b010, {busy, pullup_en, sdo_oe})
            `CHECK("no bits", 0, m.ncap)
            m.sel(1'b0, 1'b1);
            tick(6);
            `CHECK("kept low", 1'b1, ext_mode)
            m.desel;
        end
    endtask
    task t_strap;
        begin
            m.sel(1'b0, 1'b0);
            @(posedge clk_sys) srst <= 1'b1;
            repeat (6) @(posedge clk_sys);
            srst <= 1'b0;
            tick(6);
            `CHECK("strap", 4'hf, {ext_mode, busy, sdo_oe, sdo_out})
            m.desel;
        end
    endtask
    initial begin
        repeat (6) @(posedge clk_sys);
        srst <= 1'b0;
        tick(2);
        t_fill;
        t_ext_read;
        t_abort;
        t_int_read;
        t_peek;
        t_strap;
        tick(4);
        end_of_test;
    end
endmodule
